// >>> sms_supervisor.sv
// supply supervisor top: bus slave, estimate, loss, limits, ramp
//
// The implementer's own choices: register access over AHB-Lite and the register offsets.
`timescale 1ns/100ps
module sms_supervisor import sms_pkg::*; #(
	parameter int TICK_CYC = SMS_TICK_CYC,
	parameter int PERSIST_CYC = SMS_PERSIST_CYC,
	parameter int STAB_CYC = SMS_STAB_CYC
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic drive_en,
	input wire logic synced,
	input wire logic ocr_reset,
	input wire sms_meas_type meas,
	output logic vdc_ctrl_en,
	output logic [19:0] vdc_ref,
	output logic [15:0] est_v,
	output logic [15:0] preset_v,
	output logic supply_loss,
	output logic sync_allow,
	output logic resync_req,
	output logic range_trip,
	output logic [1:0] trip_code
);
	// ---------------------------------------------------------------
	// bus slave
	// ---------------------------------------------------------------
	sms_cfg_type cfg_q;
	logic wr_q;
	logic [7:0] wa_q;
	logic [31:0] rd_mux;
	logic [7:0] status;
	logic stable;
	logic tick;
	logic near_fire;
	logic range_fire;

	wire acc = hsel && hready && htrans[1];
	wire [7:0] ra = haddr[7:0];
	wire wr_ctrl = wr_q && (wa_q == SMS_OFF_CTRL);
	wire wr_vset = wr_q && (wa_q == SMS_OFF_VSET);
	wire wr_ramp = wr_q && (wa_q == SMS_OFF_RAMP);
	wire wr_loss = wr_q && (wa_q == SMS_OFF_LOSS);
	wire wr_userv = wr_q && (wa_q == SMS_OFF_USERV);
	wire wr_fmin = wr_q && (wa_q == SMS_OFF_FMIN);
	wire wr_fmax = wr_q && (wa_q == SMS_OFF_FMAX);
	wire wr_vmin = wr_q && (wa_q == SMS_OFF_VMIN);
	wire wr_vmax = wr_q && (wa_q == SMS_OFF_VMAX);

	wire [7:0] wf = hwdata[7:0];
	wire [7:0] fclamp = (wf < SMS_FLIM_LO) ? SMS_FLIM_LO :
		(wf > SMS_FLIM_HI) ? SMS_FLIM_HI : wf;
	// a zero rate would freeze the reference, so it reads back as 1
	wire [9:0] rclamp = (hwdata[9:0] == 10'h000) ? 10'h001 : hwdata[9:0];

	assign rd_mux =
		(ra == SMS_OFF_CTRL) ? {28'h000_0000, cfg_q.sync_mode, cfg_q.mode} :
		(ra == SMS_OFF_VSET) ? {16'h0000, cfg_q.vset} :
		(ra == SMS_OFF_RAMP) ? {22'h00_0000, cfg_q.ramp} :
		(ra == SMS_OFF_LOSS) ? {16'h0000, cfg_q.loss} :
		(ra == SMS_OFF_USERV) ? {16'h0000, cfg_q.user_v} :
		(ra == SMS_OFF_FMIN) ? {24'h00_0000, cfg_q.fmin} :
		(ra == SMS_OFF_FMAX) ? {24'h00_0000, cfg_q.fmax} :
		(ra == SMS_OFF_VMIN) ? {16'h0000, cfg_q.vmin} :
		(ra == SMS_OFF_VMAX) ? {16'h0000, cfg_q.vmax} :
		(ra == SMS_OFF_STAT) ? {24'h00_0000, status} :
		(ra == SMS_OFF_EST) ? {16'h0000, est_v} :
		(ra == SMS_OFF_VREF) ? {12'h000, vdc_ref} :
		32'h0000_0000;

	// zero wait states: read data sampled in the address phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_q <= 1'b0;
			wa_q <= 8'h00;
			hrdata <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			wr_q <= acc && hwrite;
			wa_q <= ra;
			hrdata <= (acc && !hwrite) ? rd_mux : 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	// configuration registers; detection mode code is delayed at reset
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cfg_q.mode <= SMS_RST_MODE;
			cfg_q.sync_mode <= SMS_RST_SYNC;
			cfg_q.vset <= SMS_RST_VSET;
			cfg_q.ramp <= SMS_RST_RAMP;
			cfg_q.loss <= SMS_RST_LOSS;
			cfg_q.user_v <= SMS_RST_USERV;
			cfg_q.fmin <= SMS_RST_FMIN;
			cfg_q.fmax <= SMS_RST_FMAX;
			cfg_q.vmin <= SMS_RST_VMIN;
			cfg_q.vmax <= SMS_RST_VMAX;
		end else begin
			if (wr_ctrl) begin
				cfg_q.mode <= sms_det_type'(hwdata[SMS_CTRL_MODE_LSB +: 2]);
				cfg_q.sync_mode <= hwdata[SMS_CTRL_SYNC_LSB +: 2];
			end
			if (wr_vset) cfg_q.vset <= hwdata[15:0];
			if (wr_ramp) cfg_q.ramp <= rclamp;
			if (wr_loss) cfg_q.loss <= hwdata[15:0];
			if (wr_userv) cfg_q.user_v <= hwdata[15:0];
			if (wr_fmin) cfg_q.fmin <= fclamp;
			if (wr_fmax) cfg_q.fmax <= fclamp;
			if (wr_vmin) cfg_q.vmin <= hwdata[15:0];
			if (wr_vmax) cfg_q.vmax <= hwdata[15:0];
		end
	end

	// ---------------------------------------------------------------
	// timers and bus stability
	// ---------------------------------------------------------------
	sms_persist #(.LIMIT(TICK_CYC)) u_tick (
		.hclk(hclk),
		.hresetn(hresetn),
		.cond(1'b1),
		.fire(tick)
	);

	sms_stable #(.WIN(STAB_CYC)) u_stable (
		.hclk(hclk),
		.hresetn(hresetn),
		.vdc(meas.vdc),
		.stable(stable)
	);

	// ---------------------------------------------------------------
	// supply estimate and loss detection
	// ---------------------------------------------------------------
	// monitored voltage source
	wire [15:0] mon_v = synced ? meas.vout : est_v;
	wire [23:0] mon_x = 24'(mon_v) * 24'(SMS_HYS_DEN);
	wire [23:0] loss_lo = 24'(cfg_q.loss) * 24'(SMS_HYS_LO);
	wire [23:0] loss_hi = 24'(cfg_q.loss) * 24'(SMS_HYS_HI);
	wire loss_d = supply_loss ? !(mon_x > loss_hi) : (mon_x < loss_lo);

	// line to line rms from the bus peak, about 1/sqrt2
	wire [31:0] rms_x = 32'(meas.vdc) * SMS_RMS_NUM;
	wire [15:0] vdc_ac = rms_x[SMS_RMS_SH +: 16];
	// mode 0 updates unsynced and stable
	wire meas_mode = cfg_q.mode == SMS_DET_MEAS;
	wire est_upd = !synced && stable;
	wire [15:0] est_d = !meas_mode ? cfg_q.user_v :
		(est_upd ? vdc_ac : est_v);

	wire half = synced && ocr_reset && (cfg_q.sync_mode == SMS_SYNC_OCR);
	wire [15:0] preset_d = half ? {1'b0, est_v[15:1]} : est_v;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			supply_loss <= 1'b0;
			est_v <= 16'h0000;
			preset_v <= 16'h0000;
		end else begin
			supply_loss <= loss_d;
			est_v <= est_d;
			preset_v <= preset_d;
		end
	end

	// ---------------------------------------------------------------
	// frequency limits and synchronization permission
	// ---------------------------------------------------------------
	// within margin of either limit
	wire [8:0] f9 = {1'b0, meas.freq};
	wire near = (f9 < ({1'b0, cfg_q.fmin} + SMS_FMARGIN)) ||
		((f9 + SMS_FMARGIN) > {1'b0, cfg_q.fmax});

	sms_persist #(.LIMIT(PERSIST_CYC)) u_near (
		.hclk(hclk),
		.hresetn(hresetn),
		.cond(near && synced),
		.fire(near_fire)
	);

	sms_state_type st_q;
	sms_state_type st_d;
	wire user_mode = cfg_q.mode == SMS_DET_USER;

	// user mode never waits for the bus
	always_comb begin
		st_d = st_q;
		case (st_q)
			SMS_WAIT_EN: begin
				if (drive_en) st_d = user_mode ? SMS_ALLOW : SMS_WAIT_STABLE;
			end
			SMS_WAIT_STABLE: begin
				if (stable) st_d = SMS_ALLOW;
			end
			SMS_ALLOW: begin
				if (supply_loss && !user_mode) st_d = SMS_WAIT_STABLE;
			end
			default: st_d = SMS_WAIT_EN;
		endcase
		if (!drive_en) st_d = SMS_WAIT_EN;
	end

	wire allow_d = (st_d == SMS_ALLOW) && !near;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_q <= SMS_WAIT_EN;
			sync_allow <= 1'b0;
			resync_req <= 1'b0;
		end else begin
			st_q <= st_d;
			sync_allow <= allow_d;
			resync_req <= near_fire && synced;
		end
	end

	// ---------------------------------------------------------------
	// voltage range trip
	// ---------------------------------------------------------------
	// zero maximum disables the check
	wire chk_on = cfg_q.vmax != 16'h0000;
	// inverted window always out of range
	wire bad_win = cfg_q.vmax <= cfg_q.vmin;
	wire below = mon_v < cfg_q.vmin;
	wire above = mon_v > cfg_q.vmax;
	wire out_rng = chk_on && (bad_win || below || above);

	sms_persist #(.LIMIT(PERSIST_CYC)) u_range (
		.hclk(hclk),
		.hresetn(hresetn),
		.cond(out_rng),
		.fire(range_fire)
	);

	wire [1:0] code_d = range_fire ?
		(below ? SMS_TRIP_LOW : SMS_TRIP_HIGH) : trip_code;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			range_trip <= 1'b0;
			trip_code <= 2'h0;
		end else begin
			range_trip <= range_fire;
			trip_code <= code_d;
		end
	end

	// ---------------------------------------------------------------
	// bus voltage controller enable and reference ramp
	// ---------------------------------------------------------------
	// enable once enabled and synced
	wire vctrl_d = drive_en && synced;
	wire [19:0] tgt = 20'(cfg_q.vset) * SMS_DECI;
	wire [19:0] stp = 20'(cfg_q.ramp);
	wire up = vdc_ref < tgt;
	wire [19:0] gap = up ? tgt - vdc_ref : vdc_ref - tgt;
	wire [19:0] ramped = (gap <= stp) ? tgt :
		(up ? vdc_ref + stp : vdc_ref - stp);
	// one rate step per millisecond
	// reference tracks the bus while off, so the ramp starts bumpless
	wire [19:0] vref_d = !vdc_ctrl_en ? 20'(meas.vdc) * SMS_DECI :
		(tick ? ramped : vdc_ref);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			vdc_ctrl_en <= 1'b0;
			vdc_ref <= 20'h0_0000;
		end else begin
			vdc_ctrl_en <= vctrl_d;
			vdc_ref <= vref_d;
		end
	end

	assign status = {near, trip_code, range_trip, sync_allow,
		vdc_ctrl_en, stable, supply_loss};

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence s_en_sync;
		drive_en && synced;
	endsequence
	sequence s_half_preset;
		synced && ocr_reset && cfg_q.sync_mode == SMS_SYNC_OCR;
	endsequence

	a_vdc_ctrl_on: assert property (s_en_sync |=> vdc_ctrl_en)
		else $error("bus controller not enabled");
	a_ramp_hold: assert property (
		(vdc_ctrl_en && vctrl_d && !tick) |=> $stable(vdc_ref))
		else $error("reference moved between ticks");
	a_ramp_step: assert property (
		(vdc_ctrl_en && vctrl_d && tick && up && gap > stp)
		|=> vdc_ref == $past(vdc_ref) + $past(stp))
		else $error("ramp step wrong");
	a_loss_set: assert property (
		(mon_x < loss_lo) |=> supply_loss)
		else $error("supply loss not flagged");
	a_loss_clear: assert property (
		$fell(supply_loss) |-> $past(mon_x > loss_hi))
		else $error("supply loss cleared early");
	a_est_hold: assert property (
		(meas_mode && synced) |=> $stable(est_v))
		else $error("estimate changed while synced");
	a_est_user: assert property (
		!meas_mode |=> est_v == $past(cfg_q.user_v))
		else $error("estimate not user value");
	a_preset_half: assert property (
		s_half_preset |=> preset_v == ($past(est_v) >> 1))
		else $error("preset not halved");
	a_near_block: assert property (near |=> !sync_allow)
		else $error("sync allowed near limit");
	a_range_off: assert property (
		!chk_on ##1 !chk_on |=> !range_trip)
		else $error("range trip while disabled");
	a_trip_code: assert property (
		range_trip |-> trip_code == SMS_TRIP_LOW ||
		trip_code == SMS_TRIP_HIGH)
		else $error("bad trip code");
endmodule

// >>> sms_pkg.sv
// package: constants, types and register map of the supply supervisor
// Function
// - enable bus controller once enabled and synced
// - ramp bus reference at set tenths of a volt per ms
// - flag supply loss below level times 0.95
// - clear supply loss above level times 1.05
// - estimate unsynced, inverter output when synced
// - mode 0: estimate from stable bus, unsynced
// - mode 0: hold estimate while synchronized
// - mode 1: estimate copies user voltage setting
// - mode 1: resync without settling, keep retrying
// - mode 2: like 1, wait stable bus
// - preset current controllers with full estimate
// - sync mode 3 overcurrent reset: half estimate
// - frequency limits 10 to 200 Hz
// - near limit 100 ms drops synchronization
// - no synchronization while near a limit
// - maximum voltage zero disables range check
// - outside window 100 ms trips, code 1/2
// - maximum not above minimum trips repeatedly
// - detection mode 0 measured, 1 user, 2 delayed
package sms_pkg;
	// ---------------------------------------------------------------
	// register offsets
	// ---------------------------------------------------------------
	localparam logic [7:0] SMS_OFF_CTRL = 8'h00;
	localparam logic [7:0] SMS_OFF_VSET = 8'h04;
	localparam logic [7:0] SMS_OFF_RAMP = 8'h08;
	localparam logic [7:0] SMS_OFF_LOSS = 8'h0C;
	localparam logic [7:0] SMS_OFF_USERV = 8'h10;
	localparam logic [7:0] SMS_OFF_FMIN = 8'h14;
	localparam logic [7:0] SMS_OFF_FMAX = 8'h18;
	localparam logic [7:0] SMS_OFF_VMIN = 8'h1C;
	localparam logic [7:0] SMS_OFF_VMAX = 8'h20;
	localparam logic [7:0] SMS_OFF_STAT = 8'h24;
	localparam logic [7:0] SMS_OFF_EST = 8'h28;
	localparam logic [7:0] SMS_OFF_VREF = 8'h2C;
	localparam int SMS_CTRL_MODE_LSB = 0;
	localparam int SMS_CTRL_SYNC_LSB = 2;
	// ---------------------------------------------------------------
	// types
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {
		SMS_DET_MEAS,
		SMS_DET_USER,
		SMS_DET_DELAY
	} sms_det_type;
	typedef enum logic [1:0] {
		SMS_WAIT_EN,
		SMS_WAIT_STABLE,
		SMS_ALLOW
	} sms_state_type;
	typedef struct packed {
		logic [15:0] vdc;
		logic [15:0] vout;
		logic [7:0] freq;
	} sms_meas_type;
	typedef struct packed {
		sms_det_type mode;
		logic [1:0] sync_mode;
		logic [15:0] vset;
		logic [9:0] ramp;
		logic [15:0] loss;
		logic [15:0] user_v;
		logic [7:0] fmin;
		logic [7:0] fmax;
		logic [15:0] vmin;
		logic [15:0] vmax;
	} sms_cfg_type;
	// ---------------------------------------------------------------
	// reset values and limits
	// ---------------------------------------------------------------
	localparam sms_det_type SMS_RST_MODE = SMS_DET_DELAY;
	localparam logic [1:0] SMS_RST_SYNC = 2'h0;
	localparam logic [15:0] SMS_RST_VSET = 16'h02BC;
	localparam logic [9:0] SMS_RST_RAMP = 10'h00A;
	localparam logic [15:0] SMS_RST_LOSS = 16'h014A;
	localparam logic [15:0] SMS_RST_USERV = 16'h0190;
	localparam logic [7:0] SMS_RST_FMIN = 8'h28;
	localparam logic [7:0] SMS_RST_FMAX = 8'h46;
	localparam logic [15:0] SMS_RST_VMIN = 16'h0000;
	localparam logic [15:0] SMS_RST_VMAX = 16'h0000;
	localparam logic [7:0] SMS_FLIM_LO = 8'h0A;
	localparam logic [7:0] SMS_FLIM_HI = 8'hC8;
	localparam logic [8:0] SMS_FMARGIN = 9'h005;
	localparam logic [1:0] SMS_SYNC_OCR = 2'h3;
	localparam logic [1:0] SMS_TRIP_LOW = 2'h1;
	localparam logic [1:0] SMS_TRIP_HIGH = 2'h2;
	localparam logic [7:0] SMS_HYS_LO = 8'h5F;
	localparam logic [7:0] SMS_HYS_HI = 8'h69;
	localparam logic [7:0] SMS_HYS_DEN = 8'h64;
	localparam logic [19:0] SMS_DECI = 20'h0_000A;
	localparam logic [31:0] SMS_RMS_NUM = 32'h0000_00B5;
	localparam int SMS_RMS_SH = 8;
	localparam logic [15:0] SMS_STAB_TOL_V = 16'h0002;
	// ---------------------------------------------------------------
	// timing
	// ---------------------------------------------------------------
	localparam int SMS_CLK_HZ = 40000000;
	localparam int SMS_TICK_MS = 1;
	localparam int SMS_PERSIST_MS = 100;
	localparam int SMS_STAB_MS = 10;
	localparam int SMS_TICK_CYC = SMS_CLK_HZ / 1000 * SMS_TICK_MS;
	localparam int SMS_PERSIST_CYC = SMS_CLK_HZ / 1000 * SMS_PERSIST_MS;
	localparam int SMS_STAB_CYC = SMS_CLK_HZ / 1000 * SMS_STAB_MS;
endpackage

// >>> sms_persist.sv
// persistence counter: pulses after a condition held for LIMIT cycles
`timescale 1ns/100ps
module sms_persist import sms_pkg::*; #(
	parameter int LIMIT = 4
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic cond,
	output logic fire
);
	localparam int W = $clog2(LIMIT + 1);
	logic [W-1:0] cnt_q;
	wire last = cnt_q == W'(LIMIT - 1);
	// restart after firing, so a held condition fires again and again
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_q <= '0;
			fire <= 1'b0;
		end else begin
			cnt_q <= (!cond || last) ? '0 : cnt_q + W'(1);
			fire <= cond && last;
		end
	end
endmodule

// >>> sms_stable.sv
// bus stability judge: compares samples one window apart
`timescale 1ns/100ps
module sms_stable import sms_pkg::*; #(
	parameter int WIN = 8
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic [15:0] vdc,
	output logic stable
);
	localparam int W = $clog2(WIN + 1);
	logic [W-1:0] cnt_q;
	logic [15:0] ref_q;
	wire last = cnt_q == W'(WIN - 1);
	wire [15:0] diff = (vdc > ref_q) ? vdc - ref_q : ref_q - vdc;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_q <= '0;
			ref_q <= '0;
			stable <= 1'b0;
		end else begin
			cnt_q <= last ? '0 : cnt_q + W'(1);
			if (last) begin
				ref_q <= vdc;
				stable <= diff <= SMS_STAB_TOL_V;
			end
		end
	end
endmodule

// >>> sms_grid_model.sv
// supply network model: bus, inverter output and frequency readings
`timescale 1ns/100ps
module sms_grid_model import sms_pkg::*; (
	input wire logic hclk,
	input wire logic slew,
	input wire logic [15:0] vdc_set,
	input wire logic [15:0] vout_set,
	input wire logic [7:0] freq_set,
	output sms_meas_type meas
);
	// ---------------------------------------------------------------
	// readings
	// ---------------------------------------------------------------
	initial meas = '0;
	// a charging bus keeps rising, so it never looks settled
	always @(posedge hclk) begin
		meas.vdc <= slew ? meas.vdc + 16'h0001 : vdc_set;
		meas.vout <= vout_set;
		meas.freq <= freq_set;
	end
endmodule

// >>> sms_supervisor_tb_top.sv
// self-checking testbench of the supply supervisor
`timescale 1ns/100ps
module sms_supervisor_tb_top import sms_pkg::*;;
	// ---------------------------------------------------------------
	// stimulus, clock and instances
	// ---------------------------------------------------------------
	localparam int TK = 4;
	localparam int PS = 20;
	localparam int ST = 8;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [31:0] haddr = 32'h0000_0000;
	logic [31:0] hwdata = 32'h0000_0000;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic drive_en = 1'b0;
	logic synced = 1'b0;
	logic ocr_reset = 1'b0;
	logic slew = 1'b0;
	logic [15:0] vdc_set = 16'h01F4;
	logic [15:0] vout_set = 16'h0190;
	logic [7:0] freq_set = 8'h32;
	sms_meas_type meas;
	logic [31:0] hrdata;
	logic hreadyout;
	logic hresp;
	logic vdc_ctrl_en;
	logic [19:0] vdc_ref;
	logic [15:0] est_v;
	logic [15:0] preset_v;
	logic supply_loss;
	logic sync_allow;
	logic resync_req;
	logic range_trip;
	logic [1:0] trip_code;
	int err_count = 0;
	int checks_done = 0;
	logic [31:0] lfsr = 32'h0000_2163;
	logic [31:0] rd;
	always #12.5 hclk = ~hclk;
	sms_supervisor #(.TICK_CYC(TK), .PERSIST_CYC(PS), .STAB_CYC(ST))
		sms_supervisor_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .drive_en(drive_en),
		.synced(synced), .ocr_reset(ocr_reset), .meas(meas),
		.vdc_ctrl_en(vdc_ctrl_en), .vdc_ref(vdc_ref), .est_v(est_v),
		.preset_v(preset_v), .supply_loss(supply_loss),
		.sync_allow(sync_allow), .resync_req(resync_req),
		.range_trip(range_trip), .trip_code(trip_code));
	sms_grid_model sms_grid_model_i (.hclk(hclk), .slew(slew),
		.vdc_set(vdc_set), .vout_set(vout_set), .freq_set(freq_set),
		.meas(meas));
	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	function automatic logic [31:0] rnd();
		lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
		return lfsr;
	endfunction
	function automatic logic [15:0] est0(input logic [15:0] v);
		return 16'((32'(v) * 32'h0000_00B5) >> 8);
	endfunction
	function automatic logic allow(input logic [7:0] f);
		return !(f < SMS_RST_FMIN + 8'h05 || f + 8'h05 > SMS_RST_FMAX);
	endfunction
	task automatic final_report();
		if (err_count == 0 && checks_done > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			err_count++;
			$display("ERROR %s expected %0h seen %0h", nm, e, g);
		end
	endtask
	// single word transfer; hready is the slave's own hreadyout
	task automatic bus(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {24'h00_0000, a};
		htrans <= 2'h2;
		hwrite <= wr;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 16);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 32);
		rd = hrdata;
		chk("bus ready", 1, n < 32);
		chk("bus response", 0, hresp);
		if (n >= 32) final_report();
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0000_0000);
		chk("register read", e, rd);
	endtask
	task automatic wt(ref logic s, input logic v, input int lim,
		input string nm);
		int n;
		n = 0;
		while (s !== v && n < lim) begin
			@(negedge hclk);
			n++;
		end
		chk(nm, v, s);
		if (s !== v) final_report();
	endtask
	// one-cycle pulses, so high cycles equal the pulse count
	task automatic cnt(ref logic s, input int cyc, input int e,
		input string nm);
		int c;
		c = 0;
		repeat (cyc) begin
			@(negedge hclk);
			if (s === 1'b1) c++;
		end
		chk(nm, e, c);
	endtask
	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	initial begin
		logic [31:0] rv [9];
		logic [15:0] u;
		int l;
		int r;
		int c;
		int st;
		logic [7:0] fq [4];
		rv = '{{28'h000_0000, SMS_RST_SYNC, SMS_RST_MODE},
			{16'h0000, SMS_RST_VSET}, {22'h00_0000, SMS_RST_RAMP},
			{16'h0000, SMS_RST_LOSS}, {16'h0000, SMS_RST_USERV},
			{24'h00_0000, SMS_RST_FMIN}, {24'h00_0000, SMS_RST_FMAX},
			32'h0000_0000, 32'h0000_0000};
		fq = '{8'h2C, 8'h2D, 8'h41, 8'h42};
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		for (int i = 0; i < 9; i++) rdc(8'(i * 4), rv[i]);
		rdc(8'h40, 32'h0000_0000);
		wr(SMS_OFF_EST, 32'h0000_1234);
		rdc(SMS_OFF_EST, {16'h0000, SMS_RST_USERV});
		wr(SMS_OFF_FMIN, 32'h0000_0005);
		rdc(SMS_OFF_FMIN, {24'h00_0000, SMS_FLIM_LO});
		wr(SMS_OFF_FMAX, 32'h0000_00FA);
		rdc(SMS_OFF_FMAX, {24'h00_0000, SMS_FLIM_HI});
		wr(SMS_OFF_FMIN, {24'h00_0000, SMS_RST_FMIN});
		wr(SMS_OFF_FMAX, {24'h00_0000, SMS_RST_FMAX});
		// loss hysteresis around a random level, user mode
		wr(SMS_OFF_CTRL, 32'h0000_0001);
		u = 16'(100 + rnd() % 500);
		wr(SMS_OFF_USERV, {16'h0000, u});
		repeat (3) @(negedge hclk);
		chk("estimate", u, est_v);
		l = 200 + rnd() % 200;
		// high estimate first, so no loss is latched from the random one
		wr(SMS_OFF_USERV, 32'h0000_0320);
		wr(SMS_OFF_LOSS, 32'(l));
		wr(SMS_OFF_USERV, 32'((l * 95 - 1) / 100 + 1));
		cnt(supply_loss, 6, 0, "loss above low");
		wr(SMS_OFF_USERV, 32'((l * 95 - 1) / 100));
		wt(supply_loss, 1'b1, 6, "loss set");
		wr(SMS_OFF_USERV, 32'(l * 105 / 100));
		cnt(supply_loss, 6, 6, "loss held");
		wr(SMS_OFF_USERV, 32'(l * 105 / 100 + 1));
		wt(supply_loss, 1'b0, 6, "loss clear");
		@(posedge hclk);
		vout_set <= 16'(l / 2);
		synced <= 1'b1;
		wt(supply_loss, 1'b1, 6, "loss on output");
		@(posedge hclk);
		vout_set <= 16'h0320;
		wt(supply_loss, 1'b0, 6, "loss off output");
		// measured estimate, held while synchronized
		wr(SMS_OFF_LOSS, {16'h0000, SMS_RST_LOSS});
		@(posedge hclk);
		synced <= 1'b0;
		wr(SMS_OFF_CTRL, 32'h0000_0000);
		repeat (3 * ST + 4) @(negedge hclk);
		chk("measured estimate", est0(16'h01F4), est_v);
		@(posedge hclk);
		synced <= 1'b1;
		vdc_set <= 16'h0258;
		repeat (3 * ST + 4) @(negedge hclk);
		chk("held estimate", est0(16'h01F4), est_v);
		@(posedge hclk);
		synced <= 1'b0;
		repeat (3 * ST + 4) @(negedge hclk);
		chk("new estimate", est0(16'h0258), est_v);
		// delayed mode waits for a settled bus, user mode does not
		wr(SMS_OFF_USERV, {16'h0000, SMS_RST_USERV});
		wr(SMS_OFF_CTRL, 32'h0000_0002);
		@(posedge hclk);
		slew <= 1'b1;
		// let the stability judge see the moving bus before enabling
		repeat (2 * ST) @(posedge hclk);
		drive_en <= 1'b1;
		cnt(sync_allow, 40, 0, "allow on moving bus");
		@(posedge hclk);
		slew <= 1'b0;
		wt(sync_allow, 1'b1, 4 * ST + 4, "allow settled");
		@(posedge hclk);
		drive_en <= 1'b0;
		slew <= 1'b1;
		wr(SMS_OFF_CTRL, 32'h0000_0001);
		@(posedge hclk);
		drive_en <= 1'b1;
		wt(sync_allow, 1'b1, 4, "allow at once");
		@(posedge hclk);
		slew <= 1'b0;
		for (int i = 0; i < 4; i++) begin
			@(posedge hclk);
			freq_set <= fq[i];
			repeat (3) @(negedge hclk);
			chk("allow near limit", allow(fq[i]), sync_allow);
		end
		@(posedge hclk);
		freq_set <= 8'h32;
		synced <= 1'b1;
		cnt(resync_req, 2 * PS + 6, 0, "no resync");
		@(posedge hclk);
		freq_set <= fq[0];
		cnt(resync_req, 2 * PS + 6, 2, "resync pulses");
		@(posedge hclk);
		freq_set <= 8'h32;
		synced <= 1'b0;
		// reference ramp at a random rate
		repeat (4) @(negedge hclk);
		chk("idle reference", 20'h0_1770, vdc_ref);
		r = 1 + rnd() % 60;
		wr(SMS_OFF_RAMP, 32'(r));
		wr(SMS_OFF_VSET, 32'h0000_0208);
		@(posedge hclk);
		synced <= 1'b1;
		@(negedge hclk);
		chk("controller off", 1'b0, vdc_ctrl_en);
		@(negedge hclk);
		chk("controller on", 1'b1, vdc_ctrl_en);
		st = (800 + r - 1) / r;
		c = 0;
		while (vdc_ref !== 20'h0_1450 && c < 4000) begin
			@(negedge hclk);
			c++;
		end
		chk("ramp time", 1, c >= (st - 1) * TK && c <= (st + 1) * TK + 4);
		// current controller preset
		wr(SMS_OFF_CTRL, 32'h0000_000D);
		@(posedge hclk);
		ocr_reset <= 1'b1;
		repeat (4) @(negedge hclk);
		chk("half preset", SMS_RST_USERV >> 1, preset_v);
		wr(SMS_OFF_CTRL, 32'h0000_0001);
		repeat (4) @(negedge hclk);
		chk("full preset", SMS_RST_USERV, preset_v);
		@(posedge hclk);
		ocr_reset <= 1'b0;
		synced <= 1'b0;
		drive_en <= 1'b0;
		// voltage range window
		wr(SMS_OFF_USERV, 32'h0000_00FA);
		wr(SMS_OFF_VMIN, 32'h0000_012C);
		cnt(range_trip, 2 * PS + 6, 0, "range off");
		wr(SMS_OFF_VMAX, 32'h0000_01F4);
		cnt(range_trip, 2 * PS + 6, 2, "low trips");
		chk("low code", SMS_TRIP_LOW, trip_code);
		wr(SMS_OFF_USERV, 32'h0000_0258);
		repeat (PS + 4) @(negedge hclk);
		chk("high code", SMS_TRIP_HIGH, trip_code);
		wr(SMS_OFF_USERV, {16'h0000, SMS_RST_USERV});
		wr(SMS_OFF_VMAX, 32'h0000_012C);
		cnt(range_trip, 2 * PS + 6, 2, "inverted trips");
		final_report();
	end
	// hang guard
	initial begin
		#2000000;
		err_count++;
		final_report();
	end
endmodule
